// file: rhp_port.sv
// One downstream port: status bits, sticky change flags and timers
`timescale 1ns/1ns
module rhp_port #(
    parameter int RESET_CYCLES  = rhp_pkg::RESET_CYCLES,
    parameter int RESYNC_CYCLES = rhp_pkg::RESYNC_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire rhp_pkg::rhp_write_type wr,
    input  wire logic                   xact_busy,
    input  wire logic                   connect_in,
    input  wire logic                   slow_in,
    input  wire logic                   overcurrent_in,
    input  wire logic                   enable_lost,
    input  wire logic                   resume_eop_done,
    input  wire logic                   fixed_device,
    output logic [31:0]                 root_port_state_reg
);

    // ************************************************************
    // Deferred write holding
    // ************************************************************
    rhp_pkg::rhp_write_type held_reg;
    logic [31:0] cmd;
    logic        apply;
    logic        port_connected_reg;
    logic        port_enabled_reg;
    logic        port_suspended_reg;
    logic        port_reset_active_reg;
    logic        port_power_on_reg;
    logic        oc_reg;
    logic        resyncing_reg;
    logic [31:0] timer_reg;
    logic        reset_done_flag_reg;
    logic        overcurrent_change_flag_reg;
    logic        resume_done_flag_reg;
    logic        enable_change_flag_reg;
    logic        connect_change_flag_reg;
    logic        connect_event;
    logic        reset_finish;
    logic        resume_finish;
    logic        probe_while_empty;

    // A write is parked while a transaction runs, then applied once
    always_ff @(posedge clk)
    begin
        if (rst)
            held_reg <= '0;
        else if (wr.valid && xact_busy)
            held_reg <= wr;
        else if (!xact_busy)
            held_reg <= '0;
    end

    assign apply = !xact_busy && (wr.valid || held_reg.valid);
    assign cmd   = wr.valid ? wr.data : held_reg.data;

    assign connect_event = connect_in != port_connected_reg;
    assign reset_finish  = port_reset_active_reg && timer_reg == 32'(RESET_CYCLES - 1);
    assign resume_finish = resyncing_reg && timer_reg == 32'(RESYNC_CYCLES - 1);
    assign probe_while_empty = apply && !port_connected_reg
        && (cmd[rhp_pkg::BIT_SET_RESET] || cmd[rhp_pkg::BIT_SET_ENABLE]
            || cmd[rhp_pkg::BIT_SET_SUSPEND]);

    // ************************************************************
    // Port state
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst || !port_power_on_reg)
        begin
            port_connected_reg    <= 1'b0;
            port_enabled_reg      <= 1'b0;
            port_suspended_reg    <= 1'b0;
            port_reset_active_reg <= 1'b0;
            resyncing_reg         <= 1'b0;
            timer_reg             <= 32'h0;
        end
        else
        begin
            port_connected_reg <= connect_in;
            if (port_reset_active_reg || resyncing_reg)
                timer_reg <= timer_reg + 32'h1;
            if (reset_finish)
            begin
                port_reset_active_reg <= 1'b0;
                port_enabled_reg      <= 1'b1;
                timer_reg             <= 32'h0;
            end
            if (resume_eop_done && port_suspended_reg)
            begin
                resyncing_reg <= 1'b1;
                timer_reg     <= 32'h0;
            end
            if (resume_finish)
            begin
                resyncing_reg      <= 1'b0;
                port_suspended_reg <= 1'b0;
            end
            if (apply && port_connected_reg)
            begin
                if (cmd[rhp_pkg::BIT_SET_RESET])
                begin
                    port_reset_active_reg <= 1'b1;
                    timer_reg             <= 32'h0;
                end
                if (cmd[rhp_pkg::BIT_SET_ENABLE])
                    port_enabled_reg <= 1'b1;
                if (cmd[rhp_pkg::BIT_CLEAR_ENABLE])
                    port_enabled_reg <= 1'b0;
                if (cmd[rhp_pkg::BIT_SET_SUSPEND])
                    port_suspended_reg <= 1'b1;
            end
            // Hardware loss of enable outranks any write in the same cycle
            if (enable_lost || connect_event || overcurrent_in)
                port_enabled_reg <= 1'b0;
        end
    end

    // Power: an overcurrent onset wins over a set-power write
    always_ff @(posedge clk)
    begin
        if (rst)
            port_power_on_reg <= 1'b0;
        else if (overcurrent_in && !oc_reg)
            port_power_on_reg <= 1'b0;
        else if (apply && cmd[rhp_pkg::BIT_CLEAR_POWER])
            port_power_on_reg <= 1'b0;
        else if (apply && cmd[rhp_pkg::BIT_SET_POWER])
            port_power_on_reg <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            oc_reg <= 1'b0;
        else
            oc_reg <= overcurrent_in;
    end

    // ************************************************************
    // Sticky change flags: a set outranks a write-one clear
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            reset_done_flag_reg         <= 1'b0;
            overcurrent_change_flag_reg <= 1'b0;
            resume_done_flag_reg        <= 1'b0;
            enable_change_flag_reg      <= 1'b0;
            connect_change_flag_reg     <= 1'b0;
        end
        else
        begin
            if (reset_finish)
                reset_done_flag_reg <= 1'b1;
            else if (apply && cmd[rhp_pkg::BIT_RESET_DONE])
                reset_done_flag_reg <= 1'b0;

            if (overcurrent_in != oc_reg)
                overcurrent_change_flag_reg <= 1'b1;
            else if (apply && cmd[rhp_pkg::BIT_OVERCUR_CHG])
                overcurrent_change_flag_reg <= 1'b0;

            if (reset_finish)
                resume_done_flag_reg <= 1'b0;
            else if (resume_finish)
                resume_done_flag_reg <= 1'b1;
            else if (apply && cmd[rhp_pkg::BIT_RESUME_DONE])
                resume_done_flag_reg <= 1'b0;

            // Only hardware causes count; write-driven disable is excluded
            if (port_enabled_reg && port_power_on_reg
                && (enable_lost || connect_event || overcurrent_in))
                enable_change_flag_reg <= 1'b1;
            else if (apply && cmd[rhp_pkg::BIT_ENABLE_CHG])
                enable_change_flag_reg <= 1'b0;

            if (fixed_device ? reset_finish
                             : (connect_event && port_power_on_reg))
                connect_change_flag_reg <= 1'b1;
            else if (probe_while_empty)
                connect_change_flag_reg <= 1'b1;
            else if (apply && cmd[rhp_pkg::BIT_CONNECT_CHG])
                connect_change_flag_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Read image: state low half, change flags high half
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (rst)
            root_port_state_reg <= rhp_pkg::PORT_REG_RESET;
        else
        begin
            root_port_state_reg <= rhp_pkg::PORT_REG_RESET;
            // State other than overcurrent is gated by power so the cycle in which power drops never
            // shows stale state bits beside a cleared power bit
            root_port_state_reg[rhp_pkg::BIT_CONNECTED]    <= port_connected_reg
                                                              && port_power_on_reg;
            root_port_state_reg[rhp_pkg::BIT_ENABLED]      <= port_enabled_reg
                                                              && port_power_on_reg;
            root_port_state_reg[rhp_pkg::BIT_SUSPENDED]    <= port_suspended_reg
                                                              && port_power_on_reg;
            root_port_state_reg[rhp_pkg::BIT_OVERCURRENT]  <= oc_reg;
            root_port_state_reg[rhp_pkg::BIT_RESET_ACTIVE] <= port_reset_active_reg
                                                              && port_power_on_reg;
            root_port_state_reg[rhp_pkg::BIT_POWER_ON]     <= port_power_on_reg;
            root_port_state_reg[rhp_pkg::BIT_SLOW_DEVICE]  <= slow_in && port_connected_reg
                                                              && port_power_on_reg;
            root_port_state_reg[rhp_pkg::BIT_CONNECT_CHG]  <= connect_change_flag_reg;
            root_port_state_reg[rhp_pkg::BIT_ENABLE_CHG]   <= enable_change_flag_reg;
            root_port_state_reg[rhp_pkg::BIT_RESUME_DONE]  <= resume_done_flag_reg;
            root_port_state_reg[rhp_pkg::BIT_OVERCUR_CHG]  <= overcurrent_change_flag_reg;
            root_port_state_reg[rhp_pkg::BIT_RESET_DONE]   <= reset_done_flag_reg;
        end
    end

endmodule : rhp_port

// file: rhp_pkg.sv
// Package: root hub port status register map, field positions and timing counts
package rhp_pkg;

    // ************************************************************
    // Command codes and sizes
    // ************************************************************
    localparam logic [7:0]  CMD_PORT1_READ  = 8'h15;
    localparam logic [7:0]  CMD_PORT2_READ  = 8'h16;
    localparam logic [7:0]  CMD_PORT1_WRITE = 8'h95;
    localparam logic [7:0]  CMD_PORT2_WRITE = 8'h96;
    localparam int          DOWNSTREAM_PORT_COUNT = 2;
    localparam logic [31:0] PORT_REG_RESET  = 32'h0000_0000;

    // ************************************************************
    // Field positions (status word and change word)
    // ************************************************************
    localparam int BIT_CONNECTED     = 0;
    localparam int BIT_ENABLED       = 1;
    localparam int BIT_SUSPENDED     = 2;
    localparam int BIT_OVERCURRENT   = 3;
    localparam int BIT_RESET_ACTIVE  = 4;
    localparam int BIT_POWER_ON      = 8;
    localparam int BIT_SLOW_DEVICE   = 9;
    localparam int BIT_CONNECT_CHG   = 16;
    localparam int BIT_ENABLE_CHG    = 17;
    localparam int BIT_RESUME_DONE   = 18;
    localparam int BIT_OVERCUR_CHG   = 19;
    localparam int BIT_RESET_DONE    = 20;
    // Write-side command bits sharing status positions
    localparam int BIT_CLEAR_ENABLE  = 0;
    localparam int BIT_SET_ENABLE    = 1;
    localparam int BIT_SET_SUSPEND   = 2;
    localparam int BIT_CLEAR_SUSPEND = 3;
    localparam int BIT_SET_RESET     = 4;
    localparam int BIT_SET_POWER     = 8;
    localparam int BIT_CLEAR_POWER   = 9;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ          = 20_000_000;
    localparam int RESET_TIME_MS   = 10;
    localparam int RESYNC_TIME_MS  = 3;
    localparam int RESET_CYCLES    = RESET_TIME_MS * (CLK_HZ / 1000);
    localparam int RESYNC_CYCLES   = RESYNC_TIME_MS * (CLK_HZ / 1000);

    // Pending register write carried from the command decoder to a port
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } rhp_write_type;

endpackage : rhp_pkg

// file: rhp_root_hub.sv
// Top: root hub port status registers behind the command-code port
`timescale 1ns/1ns
// Overview of operation
// - A port write during a transaction is held until the transaction ends.
// - Commands 15h/16h read ports one/two; 95h/96h write them.
// - One status register per downstream port, two ports.
// - Low half shows port state; high half shows change flags.
// - Reset-done flag sets when the 10 ms port reset ends.
// - Writing one clears a change flag; writing zero leaves it.
// - Overcurrent change flag sets whenever the overcurrent indicator changes.
// - Resume-done flag sets after resume pulse, slow EOP and 3 ms resync.
// - Resume-done flag is cleared when reset-done flag sets.
// - Enable change flag sets only on hardware disable, never on writes.
// - Connect change flag sets on every powered attach or detach of a non-fixed port.
// - Reset, enable or suspend write with nothing attached sets connect change.
// - Fixed-device port sets connect change only after a port reset or a reset, enable or suspend write with nothing attached.
// - Port power clears when overcurrent is detected.
module rhp_root_hub #(
    parameter int RESET_CYCLES  = rhp_pkg::RESET_CYCLES,
    parameter int RESYNC_CYCLES = rhp_pkg::RESYNC_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [31:0] cmd_wdata,
    input  wire logic [1:0]  xact_busy,
    input  wire logic [1:0]  connect_in,
    input  wire logic [1:0]  slow_in,
    input  wire logic [1:0]  overcurrent_in,
    input  wire logic [1:0]  enable_lost,
    input  wire logic [1:0]  resume_eop_done,
    input  wire logic [1:0]  fixed_device_mask,
    output logic [31:0]      rdata,
    output logic             rdata_valid
);

    // ************************************************************
    // Per-port instances
    // ************************************************************
    logic [31:0] image [rhp_pkg::DOWNSTREAM_PORT_COUNT];
    logic        is_read;

    genvar p;
    generate
        for (p = 0; p < rhp_pkg::DOWNSTREAM_PORT_COUNT; p++)
        begin : g_port
            rhp_pkg::rhp_write_type wr;
            // One assign for the whole carrier keeps it a single driver
            assign wr = {cmd_valid && cmd_code == (rhp_pkg::CMD_PORT1_WRITE + 8'(p)),
                         cmd_wdata};
            rhp_port #(
                .RESET_CYCLES  (RESET_CYCLES),
                .RESYNC_CYCLES (RESYNC_CYCLES)
            ) u_port (
                .clk                 (clk),
                .rst                 (rst),
                .wr                  (wr),
                .xact_busy           (xact_busy[p]),
                .connect_in          (connect_in[p]),
                .slow_in             (slow_in[p]),
                .overcurrent_in      (overcurrent_in[p]),
                .enable_lost         (enable_lost[p]),
                .resume_eop_done     (resume_eop_done[p]),
                .fixed_device        (fixed_device_mask[p]),
                .root_port_state_reg (image[p])
            );
        end
    endgenerate

    // ************************************************************
    // Read return, one cycle after the command
    // ************************************************************
    assign is_read = cmd_valid && (cmd_code == rhp_pkg::CMD_PORT1_READ
                                   || cmd_code == rhp_pkg::CMD_PORT2_READ);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rdata       <= 32'h0;
            rdata_valid <= 1'b0;
        end
        else
        begin
            rdata_valid <= is_read;
            if (cmd_valid && cmd_code == rhp_pkg::CMD_PORT1_READ)
                rdata <= image[0];
            else if (cmd_valid && cmd_code == rhp_pkg::CMD_PORT2_READ)
                rdata <= image[1];
        end
    end

endmodule : rhp_root_hub

// file: rhp_root_hub_chk.sv
// Checker: port-level assertions for the root hub status block
`timescale 1ns/1ns
module rhp_root_hub_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_code,
    input wire logic [31:0] rdata,
    input wire logic        rdata_valid
);
    logic rd_req;
    assign rd_req = cmd_valid && (cmd_code == rhp_pkg::CMD_PORT1_READ
                               || cmd_code == rhp_pkg::CMD_PORT2_READ);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_READ_ANSWER: assert property (rd_req |=> rdata_valid)
        else $error("read command got no answer");
    AST_NO_SPURIOUS: assert property (!rd_req |=> !rdata_valid)
        else $error("answer without a read command");
    AST_RESET_ZERO: assert property ($fell(rst) |-> rdata == 32'h0 && !rdata_valid)
        else $error("read port not cleared by reset");
    AST_UPPER_RSVD: assert property (rdata_valid |-> rdata[31:21] == 11'h0)
        else $error("reserved upper bits not zero");
    AST_LOWER_RSVD: assert property (rdata_valid |-> {rdata[15:10], rdata[7:5]} == 9'h0)
        else $error("reserved lower bits not zero");
    AST_UNPOWERED: assert property (rdata_valid && !rdata[8] |-> rdata[4] == 1'b0 && rdata[2:0] == 3'h0)
        else $error("port state shown without power");
    AST_SLOW_CONN: assert property (rdata_valid && rdata[9] |-> rdata[0])
        else $error("speed bit shown without a device");
    AST_READ_STABLE: assert property (!rdata_valid && !$past(rst) |-> $stable(rdata))
        else $error("read data moved without a read");
endmodule : rhp_root_hub_chk

bind rhp_root_hub rhp_root_hub_chk u_rhp_root_hub_chk (
    .clk         (clk),
    .rst         (rst),
    .cmd_valid   (cmd_valid),
    .cmd_code    (cmd_code),
    .rdata       (rdata),
    .rdata_valid (rdata_valid)
);

// file: rhp_dev_model.sv
// Model of the devices and bus traffic on the two downstream ports
`timescale 1ns/1ns
module rhp_dev_model (
    input  wire logic  clk,
    output logic [1:0] connect_in,
    output logic [1:0] slow_in,
    output logic [1:0] overcurrent_in,
    output logic [1:0] enable_lost,
    output logic [1:0] resume_eop_done,
    output logic [1:0] xact_busy
);
    initial
    begin
        {connect_in, slow_in, overcurrent_in} = 6'h0;
        {enable_lost, resume_eop_done, xact_busy} = 6'h0;
    end
    task automatic attach(input int p, input logic slow);
        @(negedge clk);
        connect_in[p] = 1'b1;
        slow_in[p]    = slow;
    endtask : attach
    task automatic set_oc(input int p, input logic v);
        @(negedge clk);
        overcurrent_in[p] = v;
    endtask : set_oc
    // Busy spans token through handshake of one transaction
    task automatic set_busy(input int p, input logic v);
        @(negedge clk);
        xact_busy[p] = v;
    endtask : set_busy
    task automatic lose(input int p);
        @(negedge clk);
        enable_lost[p] = 1'b1;
        @(negedge clk);
        enable_lost[p] = 1'b0;
    endtask : lose
    task automatic resume(input int p);
        @(negedge clk);
        resume_eop_done[p] = 1'b1;
        @(negedge clk);
        resume_eop_done[p] = 1'b0;
    endtask : resume
endmodule : rhp_dev_model

// file: tb_top.sv
// Testbench: command-port sequences against the root hub port registers
`timescale 1ns/1ns
module tb_top;
    localparam int RC = 20;
    localparam int RS = 10;
    logic        clk;
    logic        rst;
    logic        cmd_valid;
    logic [7:0]  cmd_code;
    logic [31:0] cmd_wdata;
    logic [1:0]  fixed_device_mask;
    logic [1:0]  connect_in, slow_in, overcurrent_in, enable_lost, resume_eop_done, xact_busy;
    logic [31:0] rdata;
    logic        rdata_valid;
    int          n_mismatch;
    int          samples_checked;
    logic [31:0] req [3] = '{32'h0000_0002, 32'h0000_0004, 32'h0000_0010};

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    rhp_root_hub #(.RESET_CYCLES(RC), .RESYNC_CYCLES(RS)) u_rhp_root_hub (
        .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .xact_busy(xact_busy), .connect_in(connect_in),
        .slow_in(slow_in), .overcurrent_in(overcurrent_in), .enable_lost(enable_lost),
        .resume_eop_done(resume_eop_done), .fixed_device_mask(fixed_device_mask),
        .rdata(rdata), .rdata_valid(rdata_valid));
    rhp_dev_model u_rhp_dev_model (
        .clk(clk), .connect_in(connect_in), .slow_in(slow_in),
        .overcurrent_in(overcurrent_in), .enable_lost(enable_lost),
        .resume_eop_done(resume_eop_done), .xact_busy(xact_busy));

    // ************************************************************
    // Access tasks
    // ************************************************************
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : check
    // Reserved bits are always written as zero by the callers
    task automatic cmd(input logic [7:0] c, input logic [31:0] d);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code  = c;
        cmd_wdata = d;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : cmd
    task automatic rd(input logic [7:0] c, input logic [31:0] m, input logic [31:0] e);
        cmd(c, 32'h0);
        check(rdata_valid === 1'b1 && (rdata & m) === e, "read value");
    endtask : rd

    initial
    begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        close_out;
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial
    begin
        {rst, cmd_valid, cmd_code, cmd_wdata, fixed_device_mask} = 44'h0;
        rst = 1'b1;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        rd(8'h15, 32'hffff_ffff, 32'h0);
        cmd(8'h14, 32'h0);
        check(rdata_valid === 1'b0, "unknown code answered");
        cmd(8'h97, 32'h0000_0100);
        rd(8'h16, 32'hffff_ffff, 32'h0);
        $display("test reset_and_codes done");
        cmd(8'h95, 32'h0000_0100);
        rd(8'h15, 32'h0000_0100, 32'h0000_0100);
        rd(8'h16, 32'hffff_ffff, 32'h0);
        u_rhp_dev_model.attach(0, 1'b1);
        repeat (4) @(negedge clk);
        rd(8'h15, 32'h0001_0301, 32'h0001_0301);
        cmd(8'h95, 32'h0);
        rd(8'h15, 32'h0001_0000, 32'h0001_0000);
        cmd(8'h95, 32'h0001_0000);
        rd(8'h15, 32'h0001_0000, 32'h0);
        $display("test attach_and_clear done");
        cmd(8'h96, 32'h0000_0100);
        for (int i = 0; i < 3; i++)
        begin
            cmd(8'h96, req[i]);
            rd(8'h16, 32'h0003_0001, 32'h0001_0000);
            cmd(8'h96, 32'h0001_0000);
        end
        $display("test request_while_empty done");
        cmd(8'h95, 32'h0000_0010);
        rd(8'h15, 32'h0010_0010, 32'h0000_0010);
        repeat (RC) @(negedge clk);
        rd(8'h15, 32'h0014_0012, 32'h0010_0002);
        cmd(8'h95, 32'h0000_0001);
        rd(8'h15, 32'h0002_0002, 32'h0);
        cmd(8'h95, 32'h0000_0002);
        u_rhp_dev_model.lose(0);
        repeat (4) @(negedge clk);
        rd(8'h15, 32'h0002_0002, 32'h0002_0000);
        $display("test reset_and_enable done");
        cmd(8'h95, 32'h0012_0002);
        cmd(8'h95, 32'h0000_0004);
        u_rhp_dev_model.resume(0);
        rd(8'h15, 32'h0004_0000, 32'h0);
        repeat (RS + 4) @(negedge clk);
        rd(8'h15, 32'h0004_0000, 32'h0004_0000);
        cmd(8'h95, 32'h0000_0010);
        repeat (RC + 4) @(negedge clk);
        rd(8'h15, 32'h0014_0000, 32'h0010_0000);
        $display("test resume done");
        // A clear issued mid-transaction must wait for the transaction to end
        u_rhp_dev_model.set_busy(0, 1'b1);
        cmd(8'h95, 32'h0010_0000);
        repeat (3) @(negedge clk);
        rd(8'h15, 32'h0010_0000, 32'h0010_0000);
        u_rhp_dev_model.set_busy(0, 1'b0);
        repeat (2) @(negedge clk);
        rd(8'h15, 32'h0010_0000, 32'h0);
        u_rhp_dev_model.set_oc(0, 1'b1);
        repeat (4) @(negedge clk);
        rd(8'h15, 32'h0008_0108, 32'h0008_0008);
        cmd(8'h95, 32'h0008_0000);
        u_rhp_dev_model.set_oc(0, 1'b0);
        repeat (4) @(negedge clk);
        rd(8'h15, 32'h0008_0008, 32'h0008_0000);
        // Clear and a fresh overcurrent change land on the same edge
        fork
            cmd(8'h95, 32'h0008_0000);
            u_rhp_dev_model.set_oc(0, 1'b1);
        join
        rd(8'h15, 32'h0008_0000, 32'h0008_0000);
        $display("test deferral_and_overcurrent done");
        fixed_device_mask = 2'b10;
        u_rhp_dev_model.attach(1, 1'b0);
        repeat (4) @(negedge clk);
        rd(8'h16, 32'h0001_0001, 32'h0000_0001);
        cmd(8'h96, 32'h0000_0010);
        repeat (RC + 4) @(negedge clk);
        rd(8'h16, 32'h0001_0000, 32'h0001_0000);
        $display("test fixed_device done");
        close_out;
    end
endmodule : tb_top
